// >>> hdl/imu_top.sv
// Integer multiply unit: decode, operand prep, result select, interlock
`timescale 1ns/1ns
`include "imu_cfg.svh"

module imu_top (
    input  wire logic           i_ref_clk,
    input  wire logic           i_rst_b,
    // Request from decode
    input  wire logic           i_req_valid,
    input  wire logic [31:0]    i_instr,
    input  wire logic [63:0]    i_opnd_a,
    input  wire logic [63:0]    i_opnd_b,
    input  wire logic           i_en_64bit,
    // Register read probe from later instructions
    input  wire logic           i_rd_valid,
    input  wire logic [4:0]     i_rd_idx,
    // Answers
    output logic                o_accept,
    output logic                o_busy,
    output logic                o_done,
    output logic [4:0]          o_dest_idx,
    output logic [63:0]         o_result,
    output logic                o_rsvd_instr_exc,
    output logic                o_not_mult,
    output logic                o_stall
);

    // ====================================================================
    // Instruction decode
    // ====================================================================
    logic [5:0]       opc;
    logic [5:0]       fn;
    logic [4:0]       sel;
    logic [4:0]       dest;
    imu_pkg::imu_op_t op;
    logic             is_dword;

    assign opc  = i_instr[`IMU_OPC_MSB:`IMU_OPC_LSB];
    assign fn   = i_instr[`IMU_FN_MSB:`IMU_FN_LSB];
    assign sel  = i_instr[`IMU_SEL_MSB:`IMU_SEL_LSB];
    assign dest = i_instr[`IMU_RD_MSB:`IMU_RD_LSB];

    // Classify the instruction into one of the multiply forms
    always_comb begin
        op = imu_pkg::IMU_OP_NONE;
        if (opc == `IMU_OP_LEGACY_GRP2 && fn == `IMU_FN_LEGACY_MUL &&
            sel == `IMU_SHAMT_ZERO) begin
            op = imu_pkg::IMU_OP_LEGACY_LOW;
        end else if (opc == `IMU_OP_PRIMARY_SPEC &&
                     (sel == `IMU_SEL_LOW || sel == `IMU_SEL_HIGH)) begin
            unique case (fn)
                `IMU_FN_SIGNED_WORD: begin
                    op = (sel == `IMU_SEL_HIGH) ? imu_pkg::IMU_OP_HIGH_WORD_S
                                                : imu_pkg::IMU_OP_LOW_WORD_S;
                end
                `IMU_FN_UNSIGNED_WORD: begin
                    op = (sel == `IMU_SEL_HIGH) ? imu_pkg::IMU_OP_HIGH_WORD_U
                                                : imu_pkg::IMU_OP_LOW_WORD_U;
                end
                `IMU_FN_SIGNED_DWORD: begin
                    op = (sel == `IMU_SEL_HIGH) ? imu_pkg::IMU_OP_HIGH_DWORD_S
                                                : imu_pkg::IMU_OP_LOW_DWORD_S;
                end
                `IMU_FN_UNSIGNED_DWORD: begin
                    op = (sel == `IMU_SEL_HIGH) ? imu_pkg::IMU_OP_HIGH_DWORD_U
                                                : imu_pkg::IMU_OP_LOW_DWORD_U;
                end
                default: begin
                    op = imu_pkg::IMU_OP_NONE;
                end
            endcase
        end
    end

    assign is_dword = (op == imu_pkg::IMU_OP_LOW_DWORD_S)  ||
                      (op == imu_pkg::IMU_OP_HIGH_DWORD_S) ||
                      (op == imu_pkg::IMU_OP_LOW_DWORD_U)  ||
                      (op == imu_pkg::IMU_OP_HIGH_DWORD_U);

    // ====================================================================
    // Control word and operand preparation
    // ====================================================================
    imu_pkg::imu_ctl_t ctl;
    logic [64:0]       opa;
    logic [64:0]       opb;

    // Build flags for the result selector
    always_comb begin
        ctl.dest      = dest;
        ctl.is_word   = !is_dword;
        ctl.is_high   = (op == imu_pkg::IMU_OP_HIGH_WORD_S)  ||
                        (op == imu_pkg::IMU_OP_HIGH_WORD_U)  ||
                        (op == imu_pkg::IMU_OP_HIGH_DWORD_S) ||
                        (op == imu_pkg::IMU_OP_HIGH_DWORD_U);
        ctl.is_signed = (op == imu_pkg::IMU_OP_LEGACY_LOW)   ||
                        (op == imu_pkg::IMU_OP_LOW_WORD_S)   ||
                        (op == imu_pkg::IMU_OP_HIGH_WORD_S)  ||
                        (op == imu_pkg::IMU_OP_LOW_DWORD_S)  ||
                        (op == imu_pkg::IMU_OP_HIGH_DWORD_S);
    end

    // Word forms use only bits 31..0; upper bits never reach the multiplier
    always_comb begin
        if (ctl.is_word) begin
            opa = ctl.is_signed ? {{33{i_opnd_a[31]}}, i_opnd_a[31:0]}
                                : {33'h0_0000_0000, i_opnd_a[31:0]};
            opb = ctl.is_signed ? {{33{i_opnd_b[31]}}, i_opnd_b[31:0]}
                                : {33'h0_0000_0000, i_opnd_b[31:0]};
        end else begin
            opa = ctl.is_signed ? {i_opnd_a[63], i_opnd_a}
                                : {1'b0, i_opnd_a};
            opb = ctl.is_signed ? {i_opnd_b[63], i_opnd_b}
                                : {1'b0, i_opnd_b};
        end
    end

    // ====================================================================
    // Request acceptance and exception
    // ====================================================================
    logic start;
    logic exc;
    logic reuse;

    // Dword forms trap when 64-bit instructions are off; word forms never
    assign exc   = i_req_valid && is_dword && !i_en_64bit;
    assign start = i_req_valid && (op != imu_pkg::IMU_OP_NONE) && !exc &&
                   !reuse;

    // Acceptance, exception and decode-miss pulses
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_accept         <= 1'b0;
            o_rsvd_instr_exc <= 1'b0;
            o_not_mult       <= 1'b0;
        end else begin
            o_accept         <= i_req_valid && (op != imu_pkg::IMU_OP_NONE)
                                && !exc;
            o_rsvd_instr_exc <= exc;
            o_not_mult       <= i_req_valid && (op == imu_pkg::IMU_OP_NONE);
        end
    end

    // ====================================================================
    // Low/high pair reuse: remember the last full product
    // ====================================================================
    logic [127:0] last_prod_r;
    logic [63:0]  last_a_r;
    logic [63:0]  last_b_r;
    logic         last_word_r;
    logic         last_sgn_r;
    logic         last_ok_r;
    logic         mc_valid;
    logic [127:0] mc_prod;
    imu_pkg::imu_ctl_t mc_ctl;
    logic         pend_any;

    assign reuse = i_req_valid && (op != imu_pkg::IMU_OP_NONE) && !exc &&
                   last_ok_r && ctl.is_high && !pend_any &&
                   i_opnd_a == last_a_r && i_opnd_b == last_b_r &&
                   ctl.is_word == last_word_r &&
                   ctl.is_signed == last_sgn_r;

    // Capture operands at issue and the product when it completes
    logic [63:0] iss_a_r;
    logic [63:0] iss_b_r;
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            iss_a_r     <= `IMU_RST_DATA;
            iss_b_r     <= `IMU_RST_DATA;
            last_a_r    <= `IMU_RST_DATA;
            last_b_r    <= `IMU_RST_DATA;
            last_prod_r <= '0;
            last_word_r <= 1'b0;
            last_sgn_r  <= 1'b0;
            last_ok_r   <= 1'b0;
        end else begin
            if (start) begin
                iss_a_r   <= i_opnd_a;
                iss_b_r   <= i_opnd_b;
                last_ok_r <= 1'b0;
            end else if (mc_valid) begin
                last_a_r    <= iss_a_r;
                last_b_r    <= iss_b_r;
                last_prod_r <= mc_prod;
                last_word_r <= mc_ctl.is_word;
                last_sgn_r  <= mc_ctl.is_signed;
                last_ok_r   <= 1'b1;
            end
        end
    end

    // ====================================================================
    // Multiplier
    // ====================================================================
    imu_mult_core u_core (
        .i_ref_clk (i_ref_clk),
        .i_rst_b   (i_rst_b),
        .i_valid   (start),
        .i_opa     (opa),
        .i_opb     (opb),
        .i_ctl     (ctl),
        .o_valid   (mc_valid),
        .o_prod    (mc_prod),
        .o_ctl     (mc_ctl)
    );

    // ====================================================================
    // Pending destination scoreboard
    // ====================================================================
    logic [4:0] pend_cnt_r;
    logic [4:0] pend_dest_r;

    assign pend_any = (pend_cnt_r != 5'h00);

    // Count in-flight multiplies and track the newest destination
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            pend_cnt_r  <= 5'h00;
            pend_dest_r <= `IMU_RST_IDX;
        end else begin
            if (start && !mc_valid) begin
                pend_cnt_r <= pend_cnt_r + 5'h01;
            end else if (!start && mc_valid) begin
                pend_cnt_r <= pend_cnt_r - 5'h01;
            end
            if (start || reuse) begin
                pend_dest_r <= dest;
            end
        end
    end

    // Stall a read of the pending destination until done
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_stall <= 1'b0;
            o_busy  <= 1'b0;
        end else begin
            o_stall <= i_rd_valid && (start || reuse ||
                       (pend_any && !(mc_valid && pend_cnt_r == 5'h01)))
                       && i_rd_idx == ((start || reuse) ? dest
                                                        : pend_dest_r);
            o_busy  <= start || (pend_any &&
                       !(mc_valid && pend_cnt_r == 5'h01));
        end
    end

    // ====================================================================
    // Result selection
    // ====================================================================
    imu_pkg::imu_res_t res_nxt;
    logic              res_vld_nxt;
    logic [127:0]      prod;
    imu_pkg::imu_ctl_t rctl;
    logic              reuse_r;
    imu_pkg::imu_ctl_t reuse_ctl_r;

    // Hold the control for a reused pair one cycle
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            reuse_r     <= 1'b0;
            reuse_ctl_r <= '0;
        end else begin
            reuse_r     <= reuse;
            reuse_ctl_r <= ctl;
        end
    end

    assign prod        = reuse_r ? last_prod_r : mc_prod;
    assign rctl        = reuse_r ? reuse_ctl_r : mc_ctl;
    assign res_vld_nxt = reuse_r || mc_valid;

    // Pick the half; word results are sign-extended from bit 31
    always_comb begin
        res_nxt.dest = rctl.dest;
        if (rctl.is_word) begin
            res_nxt.data = rctl.is_high
                ? {{32{prod[63]}}, prod[63:32]}
                : {{32{prod[31]}}, prod[31:0]};
        end else begin
            res_nxt.data = rctl.is_high ? prod[127:64]
                                        : prod[63:0];
        end
    end

    // Registered answer; the high/low result registers are not touched
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_done     <= 1'b0;
            o_dest_idx <= `IMU_RST_IDX;
            o_result   <= `IMU_RST_DATA;
        end else begin
            o_done <= res_vld_nxt;
            if (res_vld_nxt) begin
                o_dest_idx <= res_nxt.dest;
                o_result   <= res_nxt.data;
            end
        end
    end

endmodule // imu_top

// >>> hdl/imu_cfg.svh
// Constants for the integer multiply unit: opcodes, fields, latency
`ifndef IMU_CFG_SVH
`define IMU_CFG_SVH

// Major opcode groups
`define IMU_OP_LEGACY_GRP2    6'h1C
`define IMU_OP_PRIMARY_SPEC   6'h00
// Function codes
`define IMU_FN_LEGACY_MUL     6'h02
`define IMU_FN_SIGNED_WORD    6'h18
`define IMU_FN_UNSIGNED_WORD  6'h19
`define IMU_FN_SIGNED_DWORD   6'h1C
`define IMU_FN_UNSIGNED_DWORD 6'h1D
// Half select field values (bits 10..6)
`define IMU_SHAMT_ZERO        5'h00
`define IMU_SEL_LOW           5'h02
`define IMU_SEL_HIGH          5'h03
// Instruction field positions
`define IMU_OPC_MSB           31
`define IMU_OPC_LSB           26
`define IMU_RS_MSB            25
`define IMU_RS_LSB            21
`define IMU_RT_MSB            20
`define IMU_RT_LSB            16
`define IMU_RD_MSB            15
`define IMU_RD_LSB            11
`define IMU_SEL_MSB           10
`define IMU_SEL_LSB           6
`define IMU_FN_MSB            5
`define IMU_FN_LSB            0
// Multiplier pipeline depth in cycles
`define IMU_MUL_STAGES        3
// Reset values
`define IMU_RST_DATA          64'h0000_0000_0000_0000
`define IMU_RST_IDX           5'h00

`endif

// >>> hdl/imu_pkg.sv
// Types shared by the integer multiply unit
package imu_pkg;

    typedef enum logic [3:0] {
        IMU_OP_NONE,
        IMU_OP_LEGACY_LOW,
        IMU_OP_LOW_WORD_S,
        IMU_OP_HIGH_WORD_S,
        IMU_OP_LOW_WORD_U,
        IMU_OP_HIGH_WORD_U,
        IMU_OP_LOW_DWORD_S,
        IMU_OP_HIGH_DWORD_S,
        IMU_OP_LOW_DWORD_U,
        IMU_OP_HIGH_DWORD_U
    } imu_op_t;

    // Operation as it travels down the multiplier
    typedef struct packed {
        logic       is_word;
        logic       is_high;
        logic       is_signed;
        logic [4:0] dest;
    } imu_ctl_t;

    // Result handed back to the pipeline
    typedef struct packed {
        logic [4:0]  dest;
        logic [63:0] data;
    } imu_res_t;

endpackage

// >>> hdl/imu_mult_core.sv
// Pipelined 65x65 signed multiplier producing a 128-bit product
`timescale 1ns/1ns
`include "imu_cfg.svh"

module imu_mult_core (
    input  wire logic                  i_ref_clk,
    input  wire logic                  i_rst_b,
    input  wire logic                  i_valid,
    input  wire logic [64:0]           i_opa,
    input  wire logic [64:0]           i_opb,
    input  wire imu_pkg::imu_ctl_t     i_ctl,
    output logic                       o_valid,
    output logic [127:0]               o_prod,
    output imu_pkg::imu_ctl_t          o_ctl
);

    localparam int STG = `IMU_MUL_STAGES;

    logic              vld_r [STG];
    logic [129:0]      prd_r [STG];
    imu_pkg::imu_ctl_t ctl_r [STG];
    logic [129:0]      ext_a;
    logic [129:0]      ext_b;

    // Sign-extend to the full product width so no bits are lost
    assign ext_a = {{65{i_opa[64]}}, i_opa};
    assign ext_b = {{65{i_opb[64]}}, i_opb};

    // Stage 0 multiplies, later stages only delay for timing retiming
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            for (int k = 0; k < STG; k++) begin
                vld_r[k] <= 1'b0;
                prd_r[k] <= '0;
                ctl_r[k] <= '0;
            end
        end else begin
            vld_r[0] <= i_valid;
            prd_r[0] <= ext_a * ext_b;
            ctl_r[0] <= i_ctl;
            for (int k = 1; k < STG; k++) begin
                vld_r[k] <= vld_r[k-1];
                prd_r[k] <= prd_r[k-1];
                ctl_r[k] <= ctl_r[k-1];
            end
        end
    end

    assign o_valid = vld_r[STG-1];
    assign o_prod  = prd_r[STG-1][127:0];
    assign o_ctl   = ctl_r[STG-1];

endmodule // imu_mult_core

// >>> testbench/imu_top_properties.sv
// Port checker for the integer multiply unit
`timescale 1ns/1ns
`include "imu_cfg.svh"

module imu_top_properties (
    input wire logic        i_ref_clk,
    input wire logic        i_rst_b,
    input wire logic        i_req_valid,
    input wire logic [31:0] i_instr,
    input wire logic        i_en_64bit,
    input wire logic        i_rd_valid,
    input wire logic [4:0]  i_rd_idx,
    input wire logic        o_accept,
    input wire logic        o_done,
    input wire logic [4:0]  o_dest_idx,
    input wire logic [63:0] o_result,
    input wire logic        o_rsvd_instr_exc,
    input wire logic        o_not_mult,
    input wire logic        o_stall
);
    // ==========
    // Decode helpers
    logic [5:0] opc;
    logic [5:0] fn;
    logic [4:0] sel;
    logic [4:0] dst;
    logic       leg;
    logic       nw;
    logic       nw_wd;
    logic       nw_dw;
    logic       word_op;

    // Instruction fields and multiply classes
    assign opc     = i_instr[31:26];
    assign fn      = i_instr[5:0];
    assign sel     = i_instr[10:6];
    assign dst     = i_instr[15:11];
    assign leg     = opc == `IMU_OP_LEGACY_GRP2 && fn == `IMU_FN_LEGACY_MUL
                     && sel == `IMU_SHAMT_ZERO;
    assign nw      = opc == `IMU_OP_PRIMARY_SPEC && sel[4:1] == 4'h1;
    assign nw_wd   = nw && fn[5:1] == 5'h0C;
    assign nw_dw   = nw && fn[5:1] == 5'h0E;
    assign word_op = leg || nw_wd;

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_b);

    // ==========
    // Assertions
    AST_LEGACY_TAKEN: assert property (
        i_req_valid && leg |=> o_accept && !o_not_mult)
        else $error("Legacy multiply not accepted");
    AST_WORD_NO_EXC: assert property (
        i_req_valid && word_op |=> o_accept && !o_rsvd_instr_exc)
        else $error("Word multiply refused");
    AST_DWORD_REFUSED: assert property (
        i_req_valid && nw_dw && !i_en_64bit |=> o_rsvd_instr_exc && !o_accept)
        else $error("Dword form not refused");
    AST_DWORD_TAKEN: assert property (
        i_req_valid && nw_dw && i_en_64bit |=> o_accept && !o_rsvd_instr_exc)
        else $error("Dword form not accepted");
    AST_UNDECODED: assert property (
        i_req_valid && !word_op && !nw_dw |=> o_not_mult && !o_accept)
        else $error("Undecoded word not flagged");
    AST_DONE_AFTER_ACCEPT: assert property (
        o_accept |-> ##[1:3] o_done)
        else $error("Accepted request never completed");
    AST_DONE_CAUSE: assert property (
        o_done |-> $past(o_accept) || $past(o_accept, 3))
        else $error("Result strobe without a request");
    AST_DEST_INDEX: assert property (
        o_done && $past(i_req_valid, 4) && $past(o_accept, 3)
        |-> o_dest_idx == $past(dst, 4))
        else $error("Result carries wrong destination");
    AST_WORD_SEXT: assert property (
        o_done && $past(o_accept, 3) && $past(i_req_valid, 4)
        && $past(word_op, 4) |-> o_result[63:32] == {32{o_result[31]}})
        else $error("Word result not sign extended");
    AST_STALL_PENDING: assert property (
        $past(o_accept) && !o_accept && !o_done && i_rd_valid
        && i_rd_idx == $past(dst, 2) |=> o_stall)
        else $error("Read of pending destination not stalled");
endmodule // imu_top_properties

bind imu_top imu_top_properties u_props (
    .i_ref_clk       (i_ref_clk),
    .i_rst_b         (i_rst_b),
    .i_req_valid     (i_req_valid),
    .i_instr         (i_instr),
    .i_en_64bit      (i_en_64bit),
    .i_rd_valid      (i_rd_valid),
    .i_rd_idx        (i_rd_idx),
    .o_accept        (o_accept),
    .o_done          (o_done),
    .o_dest_idx      (o_dest_idx),
    .o_result        (o_result),
    .o_rsvd_instr_exc(o_rsvd_instr_exc),
    .o_not_mult      (o_not_mult),
    .o_stall         (o_stall)
);

// >>> testbench/imu_gpr_model.sv
// Register file model standing behind the result port
`timescale 1ns/1ns

module imu_gpr_model (
    input  wire logic              i_ref_clk,
    input  wire logic              i_rst_b,
    input  wire logic              i_wr_en,
    input  wire imu_pkg::imu_res_t i_res,
    input  wire logic [4:0]        i_rd_idx,
    output logic [63:0]            o_rd_data,
    output logic [31:0]            o_wr_cnt
);
    // ==========
    // Storage
    logic [63:0] gpr_r [32];

    // Write back on each result strobe at its destination
    always_ff @(posedge i_ref_clk) begin
        if (i_wr_en) begin
            gpr_r[i_res.dest] <= i_res.data;
        end
    end

    // Count writes so a refused form can be seen to leave no trace
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_wr_cnt <= 32'h0;
        end else if (i_wr_en) begin
            o_wr_cnt <= o_wr_cnt + 32'h1;
        end
    end

    // Read port
    assign o_rd_data = gpr_r[i_rd_idx];
endmodule // imu_gpr_model

// >>> testbench/imu_top_tb.sv
// Self-checking bench for the integer multiply unit
`timescale 1ns/1ns
`include "imu_cfg.svh"

module imu_top_tb;
    // ==========
    // Signals
    logic              clk, rst_b, req_valid, en_64, rd_valid;
    logic [31:0]       instr, wr_cnt;
    logic [63:0]       opa, opb, result, g_data;
    logic [4:0]        rd_idx, g_idx, dest_idx, nxt_rd;
    logic              accept, busy, done, rsvd, not_mult, stall;
    imu_pkg::imu_res_t res;
    int                error_cnt, cmp_count, lat;

    // Clock at 25 MHz
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    imu_top DUT (.i_ref_clk(clk), .i_rst_b(rst_b), .i_req_valid(req_valid),
        .i_instr(instr), .i_opnd_a(opa), .i_opnd_b(opb), .i_en_64bit(en_64),
        .i_rd_valid(rd_valid), .i_rd_idx(rd_idx), .o_accept(accept),
        .o_busy(busy), .o_done(done), .o_dest_idx(dest_idx),
        .o_result(result), .o_rsvd_instr_exc(rsvd), .o_not_mult(not_mult),
        .o_stall(stall));

    assign res = {dest_idx, result};
    imu_gpr_model u_gpr (.i_ref_clk(clk), .i_rst_b(rst_b), .i_wr_en(done),
        .i_res(res), .i_rd_idx(g_idx), .o_rd_data(g_data), .o_wr_cnt(wr_cnt));

    // ==========
    // Helpers
    task automatic chk(input logic ok, input string msg);
        cmp_count++;
        if (ok !== 1'b1) begin
            error_cnt++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask

    task automatic close_out;
        $display("Checks %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    function automatic logic [31:0] mk(input logic [5:0] op,
        input logic [4:0] sl, input logic [5:0] fc, input logic [4:0] rd);
        return {op, 5'h01, 5'h02, rd, sl, fc};
    endfunction

    // Reference product: double width, then pick the half
    function automatic logic [63:0] expv(input logic hi, dw, sg,
        input logic [63:0] a, b);
        logic [127:0] x, y, p;
        if (dw) begin
            x = sg ? {{64{a[63]}}, a} : {64'h0, a};
            y = sg ? {{64{b[63]}}, b} : {64'h0, b};
            p = x * y;
            return hi ? p[127:64] : p[63:0];
        end
        x = sg ? {{96{a[31]}}, a[31:0]} : {96'h0, a[31:0]};
        y = sg ? {{96{b[31]}}, b[31:0]} : {96'h0, b[31:0]};
        p = x * y;
        return hi ? {{32{p[63]}}, p[63:32]} : {{32{p[31]}}, p[31:0]};
    endfunction

    // One request pulse; entered and left on a falling edge
    task automatic issue(input logic [31:0] ins, input logic [63:0] a, b);
        instr = ins;
        opa = a;
        opb = b;
        req_valid = 1'b1;
        @(negedge clk);
        req_valid = 1'b0;
    endtask

    // Bounded wait for the result strobe
    task automatic wait_done(output int n);
        n = 0;
        while (done !== 1'b1 && n < 12) begin
            @(negedge clk);
            n++;
        end
        if (n >= 12) begin
            chk(1'b0, "no result strobe");
            close_out;
        end
    endtask

    task automatic run_op(input logic [5:0] op, input logic [4:0] sl,
        input logic [5:0] fc, input logic [63:0] a, b, ex);
        logic [4:0] d;
        d = nxt_rd;
        nxt_rd = nxt_rd + 5'h01;
        issue(mk(op, sl, fc, d), a, b);
        chk(accept === 1'b1 && rsvd === 1'b0, "request refused");
        wait_done(lat);
        chk(result === ex, "wrong product");
        chk(dest_idx === d, "wrong destination");
        g_idx = d;
        @(negedge clk);
        chk(g_data === ex, "register not written");
    endtask

    // ==========
    // Scenarios
    // All nine forms; junk above bit 31 on low word forms
    task automatic t_forms;
        logic [63:0] a, b;
        logic [5:0]  fc;
        en_64 = 1'b1;
        for (int i = 0; i < 8; i++) begin
            fc = 6'h18 | {3'h0, i[2], 1'h0, i[1]};
            a = i[2] ? 64'hF123_4567_89AB_CDEF :
                (i[0] ? 64'hFFFF_FFFF_9ABC_DEF1 : 64'h5A5A_0000_9ABC_DEF1);
            b = (i[0] && !i[2]) ? 64'hFFFF_FFFF_8000_0005 :
                64'h1234_5678_8000_0005;
            run_op(`IMU_OP_PRIMARY_SPEC, {4'h1, i[0]}, fc, a, b,
                expv(i[0], i[2], !i[1], a, b));
        end
        en_64 = 1'b0;
        a = 64'hFFFF_FFFF_FFFF_FFFD;
        b = 64'h0000_0000_7FFF_FFFF;
        run_op(`IMU_OP_LEGACY_GRP2, `IMU_SHAMT_ZERO, `IMU_FN_LEGACY_MUL, a, b,
            expv(1'b0, 1'b0, 1'b1, a, b));
    endtask

    // Dword forms with 64-bit disabled, then undecoded words
    task automatic t_refuse;
        logic [31:0] n0;
        en_64 = 1'b0;
        n0 = wr_cnt;
        for (int i = 0; i < 4; i++) begin
            issue(mk(`IMU_OP_PRIMARY_SPEC, {4'h1, i[0]},
                6'h1C | {5'h0, i[1]}, 5'h11), 64'h3, 64'h5);
            chk(rsvd === 1'b1 && accept === 1'b0, "no reserved trap");
            @(negedge clk);
        end
        issue(mk(`IMU_OP_PRIMARY_SPEC, 5'h00, 6'h18, 5'h12), 64'h3, 64'h5);
        chk(not_mult === 1'b1 && accept === 1'b0, "bad select taken");
        @(negedge clk);
        issue(mk(`IMU_OP_LEGACY_GRP2, 5'h01, 6'h02, 5'h12), 64'h3, 64'h5);
        chk(not_mult === 1'b1 && accept === 1'b0, "bad legacy taken");
        repeat (6) begin
            @(negedge clk);
            chk(done === 1'b0, "refused request completed");
        end
        chk(wr_cnt === n0, "refused request wrote");
    endtask

    // Two requests on consecutive cycles return in order
    task automatic t_b2b;
        en_64 = 1'b1;
        instr = mk(`IMU_OP_PRIMARY_SPEC, 5'h02, 6'h18, 5'h09);
        opa = 64'h7;
        opb = 64'hFFFF_FFFF_FFFF_FFF7;
        req_valid = 1'b1;
        @(negedge clk);
        instr = mk(`IMU_OP_PRIMARY_SPEC, 5'h03, 6'h19, 5'h0A);
        opa = 64'hFFFF_FFFF_FFFF_FFFF;
        @(negedge clk);
        req_valid = 1'b0;
        wait_done(lat);
        chk(result === 64'hFFFF_FFFF_FFFF_FFC1, "first lost");
        chk(dest_idx === 5'h09, "first dest");
        @(negedge clk);
        chk(done === 1'b1 && dest_idx === 5'h0A, "second late");
        chk(result === 64'hFFFF_FFFF_FFFF_FFF6, "second wrong");
    endtask

    // A read of the pending destination stalls, another does not
    task automatic t_stall;
        issue(mk(`IMU_OP_PRIMARY_SPEC, 5'h02, 6'h18, 5'h07), 64'h6, 64'h7);
        chk(busy === 1'b1, "not busy while in flight");
        rd_valid = 1'b1;
        rd_idx = 5'h08;
        @(negedge clk);
        chk(stall === 1'b0, "unrelated read stalled");
        rd_idx = 5'h07;
        @(negedge clk);
        chk(stall === 1'b1, "pending read not stalled");
        rd_valid = 1'b0;
        wait_done(lat);
        chk(result === 64'h2A, "stalled product wrong");
        chk(busy === 1'b0, "busy after result");
    endtask

    // Matching high half after a low half is answered early
    task automatic t_reuse;
        logic [63:0] a, b;
        a = 64'h8765_4321_0FED_CBA9;
        b = 64'h0000_0000_0001_0003;
        run_op(`IMU_OP_PRIMARY_SPEC, 5'h02, 6'h1C, a, b,
            expv(1'b0, 1'b1, 1'b1, a, b));
        chk(lat === 3, "plain latency");
        run_op(`IMU_OP_PRIMARY_SPEC, 5'h03, 6'h1C, a, b,
            expv(1'b1, 1'b1, 1'b1, a, b));
        chk(lat === 1, "reuse latency");
        run_op(`IMU_OP_PRIMARY_SPEC, 5'h03, 6'h1D, a, b,
            expv(1'b1, 1'b1, 1'b0, a, b));
    endtask

    // ==========
    // Main sequence
    initial begin
        {req_valid, rd_valid, en_64, rst_b} = 4'h0;
        instr = 32'h0;
        opa = 64'h0;
        opb = 64'h0;
        rd_idx = 5'h00;
        g_idx = 5'h00;
        nxt_rd = 5'h03;
        error_cnt = 0;
        cmp_count = 0;
        repeat (20) @(negedge clk);
        rst_b = 1'b1;
        chk(busy === 1'b0 && done === 1'b0, "not idle after reset");
        t_forms;
        t_refuse;
        t_b2b;
        t_stall;
        t_reuse;
        close_out;
    end
endmodule // imu_top_tb
